// file: sbp_mem_model.sv
`timescale 1ns/10ps
module sbp_mem_model
    import sbp_pkg::*;
(
    input wire logic i_clock,                             // DMA clock
    input wire logic i_rst,                               // Async reset, high
    input wire logic i_slow,                              // Accept only every other cycle
    output logic [sbp_pkg::NUM_READERS-1:0] o_ready       // Request accepted
);
    logic ph_q;
    // A loaded controller takes a request only on alternate cycles
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ph_q <= 1'h0;
        end else begin
            ph_q <= !ph_q;
        end
    end
    assign o_ready = i_slow ? {NUM_READERS{ph_q}} : 3'h7;
endmodule

// file: sbp_pkg.sv
package sbp_pkg;

    // DMA clock is the core clock divided by this; i_clock is that DMA clock
    localparam int DMA_CLK_DIV = 3;

    localparam int NUM_READERS = 3;
    localparam int RD_PREVIEW = 0;
    localparam int RD_RESIZER = 1;
    localparam int RD_HIST = 2;

    localparam int INTERVAL_W = 10;
    localparam int CNT_W = 15;
    localparam int RESZ_SCALE_SHIFT = 5;
    localparam int NO_SCALE_SHIFT = 0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 15'h0001;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL_WORD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SPACING = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FRAME = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_REQCNT_PREV = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_REQCNT_RESZ = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_REQCNT_HIST = 8'h20;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    // Subsystem control word: sticky events in the low bits, priority above
    localparam int NUM_OVF = 8;
    localparam int EVT_W = 11;
    localparam int EVT_FP_ERR = 8;
    localparam int EVT_DARK_ERR = 9;
    localparam int EVT_FRAME = 10;
    localparam logic [EVT_W-1:0] EVT_RESET = 11'h000;
    localparam int PRI_LSB = 16;
    localparam int PRI_W = 2;
    localparam logic [PRI_W-1:0] PRI_HIGHEST = 2'h0;

    localparam int SP_PREV_LSB = 0;
    localparam int SP_RESZ_LSB = 10;
    localparam int SP_HIST_LSB = 20;
    localparam int SP_W = 30;
    localparam logic [SP_W-1:0] SP_RESET = 30'h0000_0000;

    localparam int CFG_ENABLE = 0;
    localparam int CFG_MASTER = 1;
    localparam int CFG_LATCH = 2;
    localparam int CFG_MEM_YCC = 3;
    localparam int CFG_FPC_EN = 4;
    localparam int CFG_DARK_EN = 5;
    localparam int CFG_HPOL = 6;
    localparam int CFG_VPOL = 7;
    localparam int CFG_W = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

    localparam int FR_W = 16;
    localparam int FR_PIX_LSB = 0;
    localparam int FR_LINE_LSB = 16;
    localparam logic [DATA_W-1:0] FRAME_RESET = 32'h01E0_0280;
    localparam logic [FR_W-1:0] FR_ZERO = 16'h0000;
    localparam logic [FR_W-1:0] FR_ONE = 16'h0001;

    localparam int REQCNT_W = 16;
    localparam logic [REQCNT_W-1:0] REQCNT_ZERO = 16'h0000;
    localparam logic [REQCNT_W-1:0] REQCNT_ONE = 16'h0001;

    typedef enum logic [2:0] {
        SG_IDLE = 3'b001,
        SG_MASTER = 3'b010,
        SG_SLAVE = 3'b100
    } sbp_sync_state_t;

endpackage

// file: sbp_read_pacer.sv
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
module sbp_read_pacer
    import sbp_pkg::*;
(
    input wire logic i_clock,                                // DMA clock, 10 MHz
    input wire logic i_rst,                                  // Subsystem reset, async high
    input wire logic [sbp_pkg::ADDR_W-1:0] i_addr,           // Register byte address
    input wire logic [sbp_pkg::DATA_W-1:0] i_wdata,          // Register write data
    input wire logic i_wr,                                   // Write strobe
    input wire logic i_rd,                                   // Read strobe
    output logic [sbp_pkg::DATA_W-1:0] o_rdata,              // Read data, cycle after strobe
    input wire logic [sbp_pkg::NUM_READERS-1:0] i_from_mem,  // Reader input comes from memory
    input wire logic [sbp_pkg::NUM_READERS-1:0] i_buf_space, // Reader buffer has room
    input wire logic [sbp_pkg::NUM_READERS-1:0] i_req_ready, // Memory side takes request
    output logic [sbp_pkg::NUM_READERS-1:0] o_req_valid,     // Read request per reader
    input wire logic [sbp_pkg::NUM_OVF-1:0] i_wbuf_overflow, // Write buffer overflow pulses
    input wire logic i_fp_read_fail,                         // Fault pixel table read failed
    input wire logic i_dark_read_fail,                       // Dark frame/shading read failed
    input wire logic i_vsync_in,                             // Vertical sync pin input
    output logic o_hsync,                                    // Horizontal sync pin output
    output logic o_hsync_oe,                                 // Horizontal sync drive enable
    output logic o_vsync,                                    // Vertical sync pin output
    output logic o_vsync_oe,                                 // Vertical sync drive enable
    output logic o_sensor_enable,                            // Sensor controller enabled
    output logic o_sensor_ycc,                               // Sensor input is luma/chroma
    output logic [sbp_pkg::PRI_W-1:0] o_dma_priority,        // DMA master priority
    output logic o_irq                                       // Level interrupt
);
    import sbp_pkg::*;

    typedef struct packed {
        logic [EVT_W-1:0] evt;
        logic [PRI_W-1:0] pri;
        logic [SP_W-1:0] spacing;
        logic [EVT_W-1:0] mask;
        logic [CFG_W-1:0] cfg;
        logic [DATA_W-1:0] frame;
        logic [REQCNT_W-1:0] cnt_prev;
        logic [REQCNT_W-1:0] cnt_resz;
        logic [REQCNT_W-1:0] cnt_hist;
        logic [DATA_W-1:0] rdata;
    } sbp_regs_t;

    sbp_regs_t r_q;
    sbp_regs_t r_d;

    logic [NUM_READERS-1:0] rd_active;
    logic [NUM_READERS-1:0] rd_busy;
    logic [NUM_READERS-1:0] issued;
    logic [EVT_W-1:0] evt_set;
    logic frame_start;
    sbp_sync_state_t sync_state;
    logic mem_ycc;

    assign mem_ycc = r_q.cfg[CFG_MEM_YCC];

    // Memory-fed readers only run on the format they can take
    assign rd_active[RD_PREVIEW] = i_from_mem[RD_PREVIEW] && !mem_ycc;
    assign rd_active[RD_HIST] = i_from_mem[RD_HIST] && !mem_ycc;
    assign rd_active[RD_RESIZER] = i_from_mem[RD_RESIZER] && mem_ycc;

    // One request per reader per DMA cycle at most; each reader's programmed spacing sets its steady fetch rate
    sbp_req_pacer #(
        .SCALE_SHIFT(NO_SCALE_SHIFT)
    ) u_pace_prev (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_interval(r_q.spacing[SP_PREV_LSB +: INTERVAL_W]),
        .i_active(rd_active[RD_PREVIEW]),
        .i_buf_space(i_buf_space[RD_PREVIEW]),
        .i_req_ready(i_req_ready[RD_PREVIEW]),
        .o_req_valid(o_req_valid[RD_PREVIEW]),
        .o_busy(rd_busy[RD_PREVIEW])
    );

    sbp_req_pacer #(
        .SCALE_SHIFT(RESZ_SCALE_SHIFT)
    ) u_pace_resz (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_interval(r_q.spacing[SP_RESZ_LSB +: INTERVAL_W]),
        .i_active(rd_active[RD_RESIZER]),
        .i_buf_space(i_buf_space[RD_RESIZER]),
        .i_req_ready(i_req_ready[RD_RESIZER]),
        .o_req_valid(o_req_valid[RD_RESIZER]),
        .o_busy(rd_busy[RD_RESIZER])
    );

    sbp_req_pacer #(
        .SCALE_SHIFT(NO_SCALE_SHIFT)
    ) u_pace_hist (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_interval(r_q.spacing[SP_HIST_LSB +: INTERVAL_W]),
        .i_active(rd_active[RD_HIST]),
        .i_buf_space(i_buf_space[RD_HIST]),
        .i_req_ready(i_req_ready[RD_HIST]),
        .o_req_valid(o_req_valid[RD_HIST]),
        .o_busy(rd_busy[RD_HIST])
    );

    assign issued = o_req_valid & i_req_ready;

    // Pixel clock comes from the imager; sync timing here runs on the DMA clock
    sbp_sync_gen u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(r_q.cfg[CFG_ENABLE]),
        .i_master(r_q.cfg[CFG_MASTER]),
        .i_hpol(r_q.cfg[CFG_HPOL]),
        .i_vpol(r_q.cfg[CFG_VPOL]),
        .i_pix_per_line(r_q.frame[FR_PIX_LSB +: FR_W]),
        .i_lines(r_q.frame[FR_LINE_LSB +: FR_W]),
        .i_vsync_in(i_vsync_in),
        .o_hsync(o_hsync),
        .o_hsync_oe(o_hsync_oe),
        .o_vsync(o_vsync),
        .o_vsync_oe(o_vsync_oe),
        .o_frame_start(frame_start),
        .o_state(sync_state)
    );

    always_comb begin
        evt_set = EVT_RESET;
        evt_set[NUM_OVF-1:0] = i_wbuf_overflow;
        evt_set[EVT_FP_ERR] = i_fp_read_fail && r_q.cfg[CFG_FPC_EN];
        evt_set[EVT_DARK_ERR] = i_dark_read_fail && r_q.cfg[CFG_DARK_EN];
        evt_set[EVT_FRAME] = frame_start;
    end

    always_comb begin
        r_d = r_q;
        r_d.rdata = RDATA_ZERO;
        if (i_wr) begin
            case (i_addr)
                OFS_CTRL_WORD: begin
                    r_d.evt = r_q.evt & ~i_wdata[EVT_W-1:0];
                    r_d.pri = i_wdata[PRI_LSB +: PRI_W];
                end
                OFS_SPACING: begin
                    r_d.spacing = i_wdata[SP_W-1:0];
                end
                OFS_MASK: begin
                    r_d.mask = i_wdata[EVT_W-1:0];
                end
                OFS_CONFIG: begin
                    r_d.cfg = i_wdata[CFG_W-1:0];
                end
                OFS_FRAME: begin
                    r_d.frame = i_wdata;
                end
                default: begin
                    r_d.mask = r_q.mask;
                end
            endcase
        end
        // Hardware set beats a same-cycle software clear
        r_d.evt = r_d.evt | evt_set;
        if (issued[RD_PREVIEW]) begin
            r_d.cnt_prev = r_q.cnt_prev + REQCNT_ONE;
        end
        if (issued[RD_RESIZER]) begin
            r_d.cnt_resz = r_q.cnt_resz + REQCNT_ONE;
        end
        if (issued[RD_HIST]) begin
            r_d.cnt_hist = r_q.cnt_hist + REQCNT_ONE;
        end
        if (i_rd) begin
            case (i_addr)
                OFS_CTRL_WORD: begin
                    r_d.rdata[EVT_W-1:0] = r_q.evt;
                    r_d.rdata[PRI_LSB +: PRI_W] = r_q.pri;
                end
                OFS_SPACING: begin
                    r_d.rdata[SP_W-1:0] = r_q.spacing;
                end
                OFS_MASK: begin
                    r_d.rdata[EVT_W-1:0] = r_q.mask;
                end
                OFS_CONFIG: begin
                    r_d.rdata[CFG_W-1:0] = r_q.cfg;
                end
                OFS_FRAME: begin
                    r_d.rdata = r_q.frame;
                end
                OFS_STATE: begin
                    r_d.rdata[2:0] = sync_state;
                    r_d.rdata[6:4] = o_req_valid;
                    r_d.rdata[10:8] = rd_busy;
                    r_d.rdata[14:12] = rd_active;
                end
                OFS_REQCNT_PREV: begin
                    r_d.rdata[REQCNT_W-1:0] = r_q.cnt_prev;
                end
                OFS_REQCNT_RESZ: begin
                    r_d.rdata[REQCNT_W-1:0] = r_q.cnt_resz;
                end
                OFS_REQCNT_HIST: begin
                    r_d.rdata[REQCNT_W-1:0] = r_q.cnt_hist;
                end
                default: begin
                    r_d.rdata = RDATA_ZERO;
                end
            endcase
        end
    end

    // Subsystem reset from the power controller restores every register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            r_q <= '{evt: EVT_RESET, pri: PRI_HIGHEST, spacing: SP_RESET, mask: EVT_RESET,
                     cfg: CFG_RESET, frame: FRAME_RESET, cnt_prev: REQCNT_ZERO,
                     cnt_resz: REQCNT_ZERO, cnt_hist: REQCNT_ZERO, rdata: RDATA_ZERO};
        end else begin
            r_q <= r_d;
        end
    end

    assign o_rdata = r_q.rdata;
    assign o_irq = |(r_q.evt & r_q.mask);
    assign o_sensor_enable = r_q.cfg[CFG_ENABLE];
    assign o_sensor_ycc = mem_ycc;
    assign o_dma_priority = r_q.pri;
endmodule

// file: sbp_read_pacer_asserts.sv
`timescale 1ns/10ps
module sbp_read_pacer_asserts
    import sbp_pkg::*;
(
    input wire logic i_clock,                               // DMA clock
    input wire logic i_rst,                                 // Async reset
    input wire logic [sbp_pkg::ADDR_W-1:0] i_addr,          // Address
    input wire logic [sbp_pkg::DATA_W-1:0] i_wdata,         // Write data
    input wire logic i_wr,                                  // Write strobe
    input wire logic i_rd,                                  // Read strobe
    input wire logic [sbp_pkg::DATA_W-1:0] o_rdata,         // Read data
    input wire logic [sbp_pkg::NUM_READERS-1:0] i_from_mem, // Reader active
    input wire logic [sbp_pkg::NUM_READERS-1:0] i_buf_space,// Buffer room
    input wire logic [sbp_pkg::NUM_READERS-1:0] i_req_ready,// Request taken
    input wire logic [sbp_pkg::NUM_READERS-1:0] o_req_valid,// Request offered
    input wire logic [sbp_pkg::NUM_OVF-1:0] i_wbuf_overflow,// Overflow pulses
    input wire logic o_sensor_ycc,                          // Luma/chroma input
    input wire logic [sbp_pkg::PRI_W-1:0] o_dma_priority,   // Priority
    input wire logic o_irq                                  // Interrupt
);
    logic [SP_W-1:0] sp_q;
    logic ycc_q;
    logic [EVT_W-1:0] msk_q;
    logic [15:0] since_q [NUM_READERS];
    wire logic [PRI_W-1:0] wpri = i_wdata[PRI_LSB+1:PRI_LSB];
    // Write shadows judge spacing from ports alone
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sp_q <= SP_RESET;
            ycc_q <= 1'h0;
            msk_q <= EVT_RESET;
            for (int r = 0; r < NUM_READERS; r++) begin
                since_q[r] <= 16'hFFFF;
            end
        end else begin
            if (i_wr && i_addr == OFS_SPACING) sp_q <= i_wdata[SP_W-1:0];
            if (i_wr && i_addr == OFS_CONFIG) ycc_q <= i_wdata[CFG_MEM_YCC];
            if (i_wr && i_addr == OFS_MASK) msk_q <= i_wdata[EVT_W-1:0];
            for (int r = 0; r < NUM_READERS; r++) begin
                if (o_req_valid[r] && i_req_ready[r]) since_q[r] <= 16'h0001;
                else if (since_q[r] != 16'hFFFF) since_q[r] <= since_q[r] + 16'h0001;
            end
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    property p_need_space; o_req_valid != 3'h0 |-> (o_req_valid & ~(i_from_mem & i_buf_space)) == 3'h0; endproperty
    a_need_space: assert property (p_need_space) else $error("request without buffer room");
    property p_prev_gap; o_req_valid[RD_PREVIEW] |-> since_q[RD_PREVIEW] >= {6'h00, sp_q[9:0]}; endproperty
    a_prev_gap: assert property (p_prev_gap) else $error("preview request too soon");
    property p_resz_gap; o_req_valid[RD_RESIZER] |-> since_q[RD_RESIZER] >= {1'h0, sp_q[19:10], 5'h00}; endproperty
    a_resz_gap: assert property (p_resz_gap) else $error("resizer request too soon");
    property p_hist_gap; o_req_valid[RD_HIST] |-> since_q[RD_HIST] >= {6'h00, sp_q[29:20]}; endproperty
    a_hist_gap: assert property (p_hist_gap) else $error("histogram request too soon");
    property p_b2b;
        o_req_valid[2] && i_req_ready[2] && sp_q[29:20] <= 10'h001 ##1 i_from_mem[2] && i_buf_space[2] && !ycc_q
        |-> o_req_valid[2];
    endproperty
    a_b2b: assert property (p_b2b) else $error("zero spacing did not allow back to back");
    property p_fmt; o_req_valid != 3'h0 |-> (ycc_q ? o_req_valid == 3'h2 : !o_req_valid[1]); endproperty
    a_fmt: assert property (p_fmt) else $error("reader active in wrong input format");
    property p_ycc; i_wr && i_addr == OFS_CONFIG |=> o_sensor_ycc == ycc_q; endproperty
    a_ycc: assert property (p_ycc) else $error("format select not taken");
    property p_rdata_idle; !$past(i_rd) |-> o_rdata == RDATA_ZERO; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_pri; i_wr && i_addr == OFS_CTRL_WORD |=> o_dma_priority == $past(wpri); endproperty
    a_pri: assert property (p_pri) else $error("priority field not taken");
    property p_ovf_irq; (i_wbuf_overflow & msk_q[7:0]) != 8'h00 |=> o_irq; endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow did not raise interrupt");
    property p_irq_hold; o_irq && !(i_wr && (i_addr == OFS_CTRL_WORD || i_addr == OFS_MASK)) |=> o_irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("error bit dropped without clear");
    c_prev: cover property (o_req_valid[0] && i_req_ready[0]);
    c_resz: cover property (o_req_valid[1] && i_req_ready[1]);
    c_irq: cover property ($rose(o_irq));
endmodule
bind sbp_read_pacer sbp_read_pacer_asserts u_sbp_read_pacer_asserts (.i_clock(i_clock), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_from_mem(i_from_mem),
    .i_buf_space(i_buf_space), .i_req_ready(i_req_ready), .o_req_valid(o_req_valid),
    .i_wbuf_overflow(i_wbuf_overflow), .o_sensor_ycc(o_sensor_ycc), .o_dma_priority(o_dma_priority), .o_irq(o_irq));

// file: sbp_read_pacer_test.sv
`timescale 1ns/10ps
module sbp_read_pacer_test;
    import sbp_pkg::*;
    logic i_clock = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_fp = 1'h0, i_dark = 1'h0, slow = 1'h0, vin = 1'h1;
    logic [7:0] i_addr = 8'h00, ovf = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
    logic [2:0] from_mem = 3'h0, space = 3'h7, ready, valid;
    logic [1:0] pri;
    logic irq, hoe, vs;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    sbp_mem_model u_sbp_mem_model (.i_clock(i_clock), .i_rst(i_rst), .i_slow(slow), .o_ready(ready));
    sbp_read_pacer u_sbp_read_pacer (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_from_mem(from_mem), .i_buf_space(space),
        .i_req_ready(ready), .o_req_valid(valid), .i_wbuf_overflow(ovf), .i_fp_read_fail(i_fp),
        .i_dark_read_fail(i_dark), .i_vsync_in(vin), .o_hsync(), .o_hsync_oe(hoe), .o_vsync(vs), .o_vsync_oe(),
        .o_sensor_enable(), .o_sensor_ycc(), .o_dma_priority(pri), .o_irq(irq));
    initial begin
        forever #50 i_clock = !i_clock;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'h0;
        #1;
    endtask
    task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'h0;
        #1 chk(name, o_rdata, exp);
    endtask
    // Reader active for n sampling edges
    task automatic run(input logic [2:0] fm, input int n);
        @(posedge i_clock);
        from_mem <= fm;
        repeat (n) @(posedge i_clock);
        from_mem <= 3'h0;
        repeat (4) @(posedge i_clock);
    endtask
    task automatic pulse(input logic [7:0] o, input logic f, input logic d);
        @(posedge i_clock);
        ovf <= o;
        i_fp <= f;
        i_dark <= d;
        @(posedge i_clock);
        {ovf, i_fp, i_dark} <= 10'h000;
        #1;
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'h0;
        chk_reg("frame", OFS_FRAME, FRAME_RESET);
        chk_reg("spacing", OFS_SPACING, 32'h0000_0000);
        chk_reg("unmapped", 8'h3C, RDATA_ZERO);
        chk("priority", pri, 32'h0000_0000);
        wr(OFS_SPACING, 32'h3FFF_FFFF);
        chk_reg("spacing max", OFS_SPACING, 32'h3FFF_FFFF);
        wr(OFS_SPACING, 32'h0000_0003);
        run(3'h5, 30);
        chk_reg("preview count", OFS_REQCNT_PREV, 32'h0000_000A);
        chk_reg("hist count", OFS_REQCNT_HIST, 32'h0000_001E);
        space <= 3'h3;
        run(3'h4, 10);
        space <= 3'h7;
        chk_reg("hist no room", OFS_REQCNT_HIST, 32'h0000_001E);
        wr(OFS_SPACING, 32'h0000_0400);
        wr(OFS_CONFIG, 32'h0000_0008);
        run(3'h2, 96);
        chk_reg("resizer count", OFS_REQCNT_RESZ, 32'h0000_0003);
        run(3'h5, 10);
        chk_reg("raw off in ycc", OFS_REQCNT_PREV, 32'h0000_000A);
        wr(OFS_CONFIG, 32'h0000_0000);
        wr(OFS_SPACING, 32'h0000_0000);
        slow <= 1'h1;
        run(3'h1, 20);
        slow <= 1'h0;
        chk_reg("preview slow", OFS_REQCNT_PREV, 32'h0000_0014);
        wr(OFS_MASK, 32'h0000_07FF);
        for (int i = 0; i < NUM_OVF; i++) begin
            pulse(8'h01 << i, 1'h0, 1'h0);
            chk("irq set", irq, 32'h0000_0001);
            chk_reg("ovf bit", OFS_CTRL_WORD, 32'h0000_0001 << i);
            chk_reg("ovf sticky", OFS_CTRL_WORD, 32'h0000_0001 << i);
            wr(OFS_CTRL_WORD, 32'h0000_0001 << i);
            chk("irq clear", irq, 32'h0000_0000);
        end
        pulse(8'h00, 1'h1, 1'h1);
        chk_reg("fail gated", OFS_CTRL_WORD, 32'h0000_0000);
        wr(OFS_CONFIG, 32'h0000_0010);
        pulse(8'h00, 1'h1, 1'h0);
        chk_reg("fault pixel err", OFS_CTRL_WORD, 32'h0000_0100);
        wr(OFS_CONFIG, 32'h0000_0020);
        pulse(8'h00, 1'h0, 1'h1);
        chk_reg("dark err", OFS_CTRL_WORD, 32'h0000_0300);
        wr(OFS_CTRL_WORD, 32'h0000_0300);
        wr(OFS_MASK, 32'h0000_0000);
        pulse(8'h01, 1'h0, 1'h0);
        chk("irq masked", irq, 32'h0000_0000);
        wr(OFS_MASK, 32'h0000_0001);
        chk("irq unmasked", irq, 32'h0000_0001);
        wr(OFS_CTRL_WORD, 32'h0002_0001);
        chk("priority set", pri, 32'h0000_0002);
        chk_reg("priority read", OFS_CTRL_WORD, 32'h0002_0000);
        wr(OFS_FRAME, 32'h0002_0003);
        wr(OFS_CONFIG, 32'h0000_0007);
        wr(OFS_CONFIG, 32'h0000_0001);
        chk("sync oe", {hoe, vs}, 32'h0000_0002);
        chk_reg("master fs", OFS_CTRL_WORD, 32'h0002_0400);
        wr(OFS_CTRL_WORD, 32'h0002_0400);
        repeat (2) @(posedge i_clock);
        vin <= 1'h0;
        @(posedge i_clock);
        chk_reg("slave fs", OFS_CTRL_WORD, 32'h0002_0400);
        @(posedge i_clock);
        i_rst <= 1'h1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'h0;
        #1 chk("priority reset", pri, 32'h0000_0000);
        chk_reg("mask reset", OFS_MASK, 32'h0000_0000);
        chk_reg("config reset", OFS_CONFIG, 32'h0000_0000);
        print_verdict();
    end
endmodule

// file: sbp_req_pacer.sv
`timescale 1ns/10ps
module sbp_req_pacer
    import sbp_pkg::*;
#(
    parameter int SCALE_SHIFT = 0
) (
    input wire logic i_clock,                          // DMA clock
    input wire logic i_rst,                            // Async reset, high
    input wire logic [sbp_pkg::INTERVAL_W-1:0] i_interval, // Programmed spacing
    input wire logic i_active,                         // Reader takes input from memory
    input wire logic i_buf_space,                      // Reader buffer has room
    input wire logic i_req_ready,                      // Memory side takes request
    output logic o_req_valid,                          // Request offered
    output logic o_busy                                // Spacing still running
);
    import sbp_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } sbp_pacer_t;

    sbp_pacer_t s_q;
    sbp_pacer_t s_d;
    logic [CNT_W-1:0] span;
    logic issue;

    assign span = CNT_W'(i_interval) << SCALE_SHIFT;
    assign o_req_valid = i_active && i_buf_space && (s_q.cnt == CNT_ZERO);
    assign issue = o_req_valid && i_req_ready;
    assign o_busy = (s_q.cnt != CNT_ZERO);

    always_comb begin
        s_d = s_q;
        if (issue) begin
            // Next request may go span cycles after this one, or the next cycle when span is zero
            s_d.cnt = (span == CNT_ZERO) ? CNT_ZERO : span - CNT_ONE;
        end else if (s_q.cnt != CNT_ZERO) begin
            s_d.cnt = s_q.cnt - CNT_ONE;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{cnt: CNT_ZERO};
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// file: sbp_sync_gen.sv
`timescale 1ns/10ps
module sbp_sync_gen
    import sbp_pkg::*;
(
    input wire logic i_clock,                     // DMA clock
    input wire logic i_rst,                       // Async reset, high
    input wire logic i_enable,                    // Sensor controller enable
    input wire logic i_master,                    // 1 drive syncs, 0 follow them
    input wire logic i_hpol,                      // Horizontal sync active level
    input wire logic i_vpol,                      // Vertical sync active level
    input wire logic [sbp_pkg::FR_W-1:0] i_pix_per_line, // Frame definition width
    input wire logic [sbp_pkg::FR_W-1:0] i_lines,        // Frame definition height
    input wire logic i_vsync_in,                  // Vertical sync pin input
    output logic o_hsync,                         // Horizontal sync pin output
    output logic o_hsync_oe,                      // Horizontal sync drive enable
    output logic o_vsync,                         // Vertical sync pin output
    output logic o_vsync_oe,                      // Vertical sync drive enable
    output logic o_frame_start,                   // One-cycle frame start
    output sbp_pkg::sbp_sync_state_t o_state      // Current mode
);
    import sbp_pkg::*;

    typedef struct packed {
        sbp_sync_state_t state;
        logic [FR_W-1:0] pix;
        logic [FR_W-1:0] line;
        logic vin;
        logic fs;
    } sbp_sync_t;

    sbp_sync_t s_q;
    sbp_sync_t s_d;
    logic line_end;
    logic frame_end;
    logic vin_act;

    assign line_end = (s_q.pix + FR_ONE >= i_pix_per_line);
    assign frame_end = line_end && (s_q.line + FR_ONE >= i_lines);
    assign vin_act = (i_vsync_in == i_vpol);

    always_comb begin
        s_d = s_q;
        s_d.fs = 1'b0;
        s_d.vin = vin_act;
        case (s_q.state)
            SG_IDLE: begin
                s_d.pix = FR_ZERO;
                s_d.line = FR_ZERO;
                if (i_enable && i_master) begin
                    s_d.state = SG_MASTER;
                    s_d.fs = 1'b1;
                end else if (i_enable) begin
                    s_d.state = SG_SLAVE;
                end
            end
            SG_MASTER: begin
                s_d.pix = line_end ? FR_ZERO : s_q.pix + FR_ONE;
                if (frame_end) begin
                    s_d.line = FR_ZERO;
                    // A cleared enable lets the current frame finish first
                    if (!i_enable || !i_master) begin
                        s_d.state = SG_IDLE;
                    end else begin
                        s_d.fs = 1'b1;
                    end
                end else if (line_end) begin
                    s_d.line = s_q.line + FR_ONE;
                end
            end
            SG_SLAVE: begin
                s_d.fs = vin_act && !s_q.vin;
                if (!i_enable || i_master) begin
                    s_d.state = SG_IDLE;
                end
            end
            default: begin
                s_d.state = SG_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{state: SG_IDLE, pix: FR_ZERO, line: FR_ZERO, vin: 1'b0, fs: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_hsync_oe = (s_q.state == SG_MASTER);
    assign o_vsync_oe = (s_q.state == SG_MASTER);
    assign o_hsync = ((s_q.pix == FR_ZERO) && o_hsync_oe) ? i_hpol : !i_hpol;
    assign o_vsync = ((s_q.line == FR_ZERO) && o_vsync_oe) ? i_vpol : !i_vpol;
    assign o_frame_start = s_q.fs;
    assign o_state = s_q.state;
endmodule
